/* src/ppfs_pkg.sv */
// constants shared by the parallel port fifo and strobe generator
package ppfs_pkg;
  localparam int PPFS_DEPTH = 8;
  localparam int PPFS_DW = 16;
  localparam int PPFS_LINES = 8;
  // register byte offsets
  localparam logic [7:0] OFS_CFG_ONE = 8'h00;
  localparam logic [7:0] OFS_CFG_TWO = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_DATA = 8'h0c;
  localparam logic [7:0] OFS_COUNT = 8'h10;
  localparam logic [7:0] OFS_ECC = 8'h14;
  // parallel_config_one fields
  localparam int C1_EDGE_LSB = 0;
  localparam int C1_POL = 3;
  localparam int C1_DIV_LSB = 4;
  localparam int C1_DIR_IN = 7;
  localparam int C1_SMP_EDGE = 8;
  localparam int C1_RS_EN = 9;
  localparam int C1_START = 15;
  localparam int C1_W = 10;
  // parallel_config_two fields
  localparam int C2_IDLE = 0;
  localparam int C2_SWAP = 1;
  localparam int C2_EN_LSB = 4;
  localparam int C2_FRST = 13;
  localparam int C2_W = 12;
  // parallel_status_reg fields
  localparam int ST_FULL = 0;
  localparam int ST_EMPTY = 1;
  localparam int ST_EOT = 2;
  localparam int ST_LASTW = 3;
  localparam int ST_RUN = 4;
  // reset values
  localparam logic [C1_W-1:0] CFG_ONE_RST = 10'h000;
  localparam logic [C2_W-1:0] CFG_TWO_RST = 12'h000;
  localparam logic [15:0] COUNT_RST = 16'h0000;
endpackage : ppfs_pkg

/* src/ppfs_sync2.sv */
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module ppfs_sync2 #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ppfs_sync_t;
  ppfs_sync_t s_q;
  ppfs_sync_t s_d;

  always_comb begin
    s_d.s1 = d;
    s_d.s2 = s_q.s1;
    if (!rst_n) begin
      s_d = '0;
    end
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  assign q = s_q.s2;
endmodule : ppfs_sync2

/* src/ppfs_strobe_gen.sv */
// strobe cycle counter and control line shaper
`timescale 1ns/1ps
module ppfs_strobe_gen (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic [2:0] div,
  input wire logic [2:0] edge_pos,
  input wire logic pol,
  input wire logic idle_lvl,
  output logic line,
  output logic busy,
  output logic cyc_start,
  output logic cyc_end,
  output logic edge_hit,
  output logic edge_ok
);
  typedef struct packed {
    logic [2:0] cnt;
    logic busy;
    logic line;
  } ppfs_gen_t;
  ppfs_gen_t s_q;
  ppfs_gen_t s_d;

  always_comb begin
    edge_ok = (edge_pos != 3'h0) && (edge_pos <= div);
    cyc_end = s_q.busy && (s_q.cnt == div);
    cyc_start = go && (!s_q.busy || cyc_end);
    edge_hit = s_q.busy && edge_ok && (s_q.cnt == edge_pos);
    s_d = s_q;
    if (cyc_start) begin
      s_d.cnt = 3'h0;
      s_d.busy = 1'b1;
    end else if (cyc_end) begin
      s_d.cnt = 3'h0;
      s_d.busy = 1'b0;
    end else if (s_q.busy) begin
      s_d.cnt = s_q.cnt + 3'h1;
    end
    if (!s_d.busy) begin
      s_d.line = idle_lvl;
    end else if (edge_ok && (s_d.cnt >= edge_pos)) begin
      s_d.line = pol;
    end else begin
      s_d.line = ~pol;
    end
    if (!rst_n) begin
      s_d = '0;
    end
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  assign line = s_q.line;
  assign busy = s_q.busy;
endmodule : ppfs_strobe_gen

/* src/ppfs_top.sv */
// parallel port fifo, double buffer and strobe control with apb registers
//
// What this block does
// - input mode: empty fifo takes a full communication buffer and goes full
// - input mode: each data read pops oldest word; eighth read empties fifo
// - fifo exchanges with the two communication buffers in round robin
// - swap bit reverses word bytes on input reads and output writes
// - input mode data read stalls the bus until the fifo is full
// - partial last block marks fifo full; writing fifo reset empties it
// - last received word is kept and fed to the ecc and rs units
// - output mode: each data write stores next word; eighth write fills
// - output mode: full fifo copies into free buffer, then reads empty
// - last word loaded flag sets when the final expected word is written
// - output mode writes to a full fifo are dropped
// - partial output block is copied on last word; later writes dropped
// - output data is driven at cycle start and held for the whole strobe cycle
// - ecc and rs units see exactly the words driven on the pins
// - one strobe feeds eight lines, each with its own output enable
// - one strobe pulse for every word sent or received
// - enabled lines sit at idle level whenever no transfer runs
// - strobe period is divider plus one base clock periods
// - strobe edge sits edge position periods in; invalid means no edge
// - polarity zero starts high and falls, one starts low and rises
// - input data sampled at cycle end or on the strobe edge
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
module ppfs_top
  import ppfs_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [PPFS_DW-1:0] DATA_IN,
  output logic [PPFS_DW-1:0] DATA_OUT,
  output logic DATA_OE_N,
  output logic [PPFS_LINES-1:0] CTRL_OUT,
  output logic [PPFS_LINES-1:0] CTRL_OE_N,
  output logic [PPFS_DW-1:0] ECC_DATA,
  output logic ECC_VALID,
  output logic RS_VALID
);
  typedef struct packed {
    logic [C1_W-1:0] cfg1;
    logic [C2_W-1:0] cfg2;
    logic [15:0] xcount;
    logic [PPFS_DEPTH-1:0][PPFS_DW-1:0] fifo;
    logic [3:0] fcnt;
    logic [2:0] frd;
    logic full;
    logic [1:0][PPFS_DEPTH-1:0][PPFS_DW-1:0] bufs;
    logic [1:0][3:0] bcnt;
    logic [1:0] bval;
    logic xsel;
    logic lsel;
    logic [2:0] lidx;
    logic running;
    logic eot;
    logic lastw;
    logic [15:0] wr_left;
    logic [15:0] iss_left;
    logic [15:0] smp_left;
    logic [PPFS_DW-1:0] dout;
    logic doe_n;
    logic [PPFS_LINES-1:0] coe_n;
    logic [PPFS_DW-1:0] ecc;
    logic eccv;
    logic rsv;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ppfs_state_t;

  ppfs_state_t q;
  ppfs_state_t d;

  logic [PPFS_DW-1:0] din_s;
  logic gen_line;
  logic gen_busy;
  logic cyc_start;
  logic cyc_end;
  logic edge_hit;
  logic edge_ok;
  logic go;
  logic smp;
  logic dir_in;
  logic swap;
  logic access;
  logic stall;
  logic [PPFS_DW-1:0] wword;
  logic [PPFS_DW-1:0] rword;
  logic take;
  logic frst_hit;
  logic start_hit;
  logic in_room;
  logic out_ready;
  logic link_done;

  ppfs_sync2 #(
    .W(PPFS_DW)
  ) u_sync (
    .clk(CLK),
    .rst_n(RST_N),
    .d(DATA_IN),
    .q(din_s)
  );

  ppfs_strobe_gen u_gen (
    .clk(CLK),
    .rst_n(RST_N),
    .go(go),
    .div(q.cfg1[C1_DIV_LSB +: 3]),
    .edge_pos(q.cfg1[C1_EDGE_LSB +: 3]),
    .pol(q.cfg1[C1_POL]),
    .idle_lvl(q.cfg2[C2_IDLE]),
    .line(gen_line),
    .busy(gen_busy),
    .cyc_start(cyc_start),
    .cyc_end(cyc_end),
    .edge_hit(edge_hit),
    .edge_ok(edge_ok)
  );

  always_comb begin
    dir_in = q.cfg1[C1_DIR_IN];
    swap = q.cfg2[C2_SWAP];
    // sample point for incoming words
    if (q.cfg1[C1_SMP_EDGE] && edge_ok) begin
      smp = dir_in && edge_hit;
    end else begin
      smp = dir_in && cyc_end;
    end
    // permission for the next strobe cycle; an unavailable buffer holds the line at idle
    in_room = !q.bval[q.lsel] && !(smp && (q.lidx == 3'h7));
    out_ready = q.bval[q.lsel];
    if (dir_in) begin
      go = q.running && (q.iss_left != 16'h0) && in_room;
    end else begin
      go = q.running && (q.iss_left != 16'h0) && out_ready;
    end
    access = PSEL && PENABLE && !q.pready;
    stall = dir_in && !q.full && !PWRITE && (PADDR == OFS_DATA);
    take = access && !stall;
    frst_hit = take && PWRITE && (PADDR == OFS_CFG_TWO) && PWDATA[C2_FRST];
    start_hit = take && PWRITE && (PADDR == OFS_CFG_ONE) && PWDATA[C1_START];
    link_done = q.running && (q.iss_left == 16'h0) && !gen_busy && (!dir_in || (q.smp_left == 16'h0));
    wword = swap ? {PWDATA[7:0], PWDATA[15:8]} : PWDATA[15:0];
    rword = swap ? {q.fifo[q.frd][7:0], q.fifo[q.frd][15:8]} : q.fifo[q.frd];

    d = q;
    d.pready = 1'b0;
    d.pslverr = 1'b0;
    d.eccv = 1'b0;
    d.rsv = 1'b0;

    // apb slave
    if (take) begin
      d.pready = 1'b1;
      d.prdata = 32'h0;
      if (PADDR[1:0] != 2'h0) begin
        d.pslverr = 1'b1;
      end else if (PWRITE) begin
        case (PADDR)
          OFS_CFG_ONE: d.cfg1 = PWDATA[C1_W-1:0];
          OFS_CFG_TWO: begin
            d.cfg2 = PWDATA[C2_W-1:0];
            d.coe_n = ~PWDATA[C2_EN_LSB +: PPFS_LINES];
          end
          OFS_COUNT: d.xcount = PWDATA[15:0];
          OFS_DATA: begin
            if (!dir_in && !q.full && !q.lastw) begin
              d.fifo[q.fcnt[2:0]] = wword;
              d.fcnt = q.fcnt + 4'h1;
              if (q.fcnt == 4'h7) begin
                d.full = 1'b1;
              end
              if (q.wr_left != 16'h0) begin
                d.wr_left = q.wr_left - 16'h1;
              end
              if (q.wr_left == 16'h1) begin
                d.lastw = 1'b1;
              end
            end
          end
          OFS_STATUS: ;
          OFS_ECC: ;
          default: d.pslverr = 1'b1;
        endcase
      end else begin
        case (PADDR)
          OFS_CFG_ONE: d.prdata[C1_W-1:0] = q.cfg1;
          OFS_CFG_TWO: d.prdata[C2_W-1:0] = q.cfg2;
          OFS_COUNT: d.prdata[15:0] = q.xcount;
          OFS_ECC: d.prdata[15:0] = q.ecc;
          OFS_STATUS: begin
            d.prdata[ST_FULL] = q.full;
            d.prdata[ST_EMPTY] = (q.fcnt == 4'h0) && !q.full;
            d.prdata[ST_EOT] = q.eot;
            d.prdata[ST_LASTW] = q.lastw;
            d.prdata[ST_RUN] = q.running;
          end
          OFS_DATA: begin
            if (dir_in) begin
              d.prdata[15:0] = rword;
              d.frd = q.frd + 3'h1;
              if ({1'b0, q.frd} + 4'h1 == q.fcnt) begin
                d.full = 1'b0;
                d.fcnt = 4'h0;
                d.frd = 3'h0;
              end
            end
          end
          default: d.pslverr = 1'b1;
        endcase
      end
    end

    // status reset first, so a buffer copy in the same cycle wins
    if (frst_hit) begin
      d.fcnt = 4'h0;
      d.frd = 3'h0;
      d.full = 1'b0;
    end

    // fifo and buffer exchange
    if (dir_in) begin
      // input mode: copy a filled buffer into an empty fifo
      if ((q.fcnt == 4'h0) && !q.full && q.bval[q.xsel]) begin
        d.fifo = q.bufs[q.xsel];
        d.fcnt = q.bcnt[q.xsel];
        d.frd = 3'h0;
        d.full = 1'b1;
        d.bval[q.xsel] = 1'b0;
        d.xsel = ~q.xsel;
      end
    end else begin
      // output mode: hand a full or final fifo to a free buffer
      if ((q.full || (q.lastw && (q.fcnt != 4'h0))) && !q.bval[q.xsel]) begin
        d.bufs[q.xsel] = q.fifo;
        d.bcnt[q.xsel] = q.fcnt;
        d.bval[q.xsel] = 1'b1;
        d.fcnt = 4'h0;
        d.full = 1'b0;
        d.xsel = ~q.xsel;
      end
    end

    // link side
    if (cyc_start) begin
      d.iss_left = q.iss_left - 16'h1;
      if (!dir_in) begin
        d.dout = q.bufs[q.lsel][q.lidx];
        d.doe_n = 1'b0;
        d.ecc = q.bufs[q.lsel][q.lidx];
        d.eccv = 1'b1;
        d.rsv = q.cfg1[C1_RS_EN];
        d.lidx = q.lidx + 3'h1;
        if ({1'b0, q.lidx} + 4'h1 == q.bcnt[q.lsel]) begin
          d.bval[q.lsel] = 1'b0;
          d.lidx = 3'h0;
          d.lsel = ~q.lsel;
        end
      end
    end else if (cyc_end) begin
      d.doe_n = 1'b1;
    end

    // input word capture at the sample point
    if (smp) begin
      d.bufs[q.lsel][q.lidx] = din_s;
      d.ecc = din_s;
      d.eccv = 1'b1;
      d.rsv = q.cfg1[C1_RS_EN];
      d.smp_left = q.smp_left - 16'h1;
      d.lidx = q.lidx + 3'h1;
      if ((q.lidx == 3'h7) || (q.smp_left == 16'h1)) begin
        d.bval[q.lsel] = 1'b1;
        d.bcnt[q.lsel] = {1'b0, q.lidx} + 4'h1;
        d.lidx = 3'h0;
        d.lsel = ~q.lsel;
      end
    end

    // end of transfer
    if (link_done) begin
      d.running = 1'b0;
      d.eot = 1'b1;
    end

    // start pulse
    if (start_hit) begin
      d.running = 1'b1;
      d.eot = 1'b0;
      d.lastw = 1'b0;
      d.fcnt = 4'h0;
      d.frd = 3'h0;
      d.full = 1'b0;
      d.bval = 2'h0;
      d.xsel = 1'b0;
      d.lsel = 1'b0;
      d.lidx = 3'h0;
      d.doe_n = 1'b1;
      d.wr_left = q.xcount;
      d.iss_left = q.xcount;
      d.smp_left = PWDATA[C1_DIR_IN] ? q.xcount : 16'h0;
    end

    if (!RST_N) begin
      d = '0;
      d.cfg1 = CFG_ONE_RST;
      d.cfg2 = CFG_TWO_RST;
      d.xcount = COUNT_RST;
      d.doe_n = 1'b1;
      d.coe_n = '1;
    end
  end

  always_ff @(posedge CLK) begin
    q <= d;
  end

  assign PRDATA = q.prdata;
  assign PREADY = q.pready;
  assign PSLVERR = q.pslverr;
  assign DATA_OUT = q.dout;
  assign DATA_OE_N = q.doe_n;
  assign CTRL_OUT = {PPFS_LINES{gen_line}};
  assign CTRL_OE_N = q.coe_n;
  assign ECC_DATA = q.ecc;
  assign ECC_VALID = q.eccv;
  assign RS_VALID = q.rsv;
endmodule : ppfs_top

/* verif/ppfs_props.sv */
// pin checks for the parallel port block
`timescale 1ns/1ps
module ppfs_props
  import ppfs_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic PREADY,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [15:0] DATA_OUT,
  input wire logic DATA_OE_N,
  input wire logic [7:0] CTRL_OUT,
  input wire logic [15:0] ECC_DATA,
  input wire logic ECC_VALID
);
  logic [9:0] c1_q;
  logic [11:0] c2_q;
  logic [3:0] cnt_q;
  logic gap_q;
  logic wr;
  logic ok;
  assign wr = PSEL && PENABLE && PWRITE && !PREADY;
  assign ok = c1_q[2:0] != 3'h0 && c1_q[2:0] <= c1_q[6:4];
  // shadow config and count clocks since each output cycle start
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      c1_q <= 10'h000;
      c2_q <= 12'h000;
      cnt_q <= 4'h0;
      gap_q <= 1'b1;
    end else begin
      if (wr && PADDR == OFS_CFG_ONE) c1_q <= PWDATA[9:0];
      if (wr && PADDR == OFS_CFG_TWO) c2_q <= PWDATA[11:0];
      cnt_q <= ECC_VALID ? 4'h1 : cnt_q + 4'h1;
      gap_q <= !ECC_VALID && (gap_q || DATA_OE_N);
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  chk_reset_state: assert property ($rose(RST_N) |-> DATA_OE_N && !ECC_VALID && CTRL_OUT == 8'h00)
    else $error("outputs not in reset state");
  chk_lines_same: assert property (CTRL_OUT == 8'h00 || CTRL_OUT == 8'hff)
    else $error("control lines differ");
  chk_data_hold: assert property (ECC_VALID && !DATA_OE_N |=> !DATA_OE_N && $stable(DATA_OUT))
    else $error("data word not held");
  chk_ecc_feed: assert property (ECC_VALID && !DATA_OE_N |-> ECC_DATA == DATA_OUT)
    else $error("ecc word differs from pins");
  chk_start_level: assert property (ECC_VALID && !DATA_OE_N |-> CTRL_OUT[0] == !c1_q[3])
    else $error("cycle start level wrong");
  chk_edge_pos: assert property (!DATA_OE_N && !ECC_VALID && ok && cnt_q == {1'b0, c1_q[2:0]} |->
    CTRL_OUT[0] == c1_q[3]) else $error("strobe edge misplaced");
  chk_period_len: assert property (ECC_VALID && !DATA_OE_N && !gap_q |-> cnt_q == {1'b0, c1_q[6:4]} + 4'h1)
    else $error("strobe period wrong");
  chk_idle_level: assert property (DATA_OE_N && $past(DATA_OE_N) && !c1_q[7] && $stable(c2_q[0]) |->
    CTRL_OUT == {8{c2_q[0]}}) else $error("idle level wrong");
endmodule : ppfs_props

/* verif/ppfs_dev.sv */
// far-side device model: a new word after each strobe fall while armed
`timescale 1ns/1ps
module ppfs_dev (
  input wire logic clk,
  input wire logic arm,
  input wire logic line,
  output logic [15:0] data
);
  logic [15:0] idx_q = 16'h0000;
  logic line_q = 1'b0;
  initial data = 16'h5a5a;
  always @(posedge clk) begin
    line_q <= line;
    if (!arm) idx_q <= 16'h0000;
    if (arm && line_q && !line) begin
      data <= 16'h3c00 + idx_q;
      idx_q <= idx_q + 16'h0001;
    end else if (!line_q && line) begin
      data <= ~data;
    end
  end
endmodule : ppfs_dev

/* verif/tb.sv */
// bench for the parallel port fifo and strobe block
`timescale 1ns/1ps
module tb;
  import ppfs_pkg::*;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, arm = 0, om = 0;
  logic [7:0] pa = 8'h00;
  logic [31:0] pw = 32'h0, prd, rd;
  logic prdy, perr, doe, ev, rv;
  logic [15:0] din, dout, ed, w;
  logic [7:0] co, coe;
  logic [32:0] e, m;
  logic [32:0] qe[$], qm[$];
  logic [15:0] qp[$], wd[$];
  int n_fail = 0, compares = 0, seed = 90238;
  always #50 clk = ~clk;
  ppfs_top ppfs_top_inst (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(pa),
    .PWDATA(pw), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr), .DATA_IN(din), .DATA_OUT(dout),
    .DATA_OE_N(doe), .CTRL_OUT(co), .CTRL_OE_N(coe), .ECC_DATA(ed), .ECC_VALID(ev), .RS_VALID(rv));
  ppfs_dev ppfs_dev_inst (.clk(clk), .arm(arm), .line(co[0]), .data(din));
  task automatic chk(input logic [32:0] g, input logic [32:0] x, input logic [32:0] k);
    compares++;
    if ((g & k) !== (x & k)) begin
      n_fail++;
      $display("mismatch at %0t: got %h want %h", $time, g, x);
    end
  endtask : chk
  task automatic acc(input logic wn, input logic [7:0] a, input logic [31:0] d, input logic [32:0] x,
    input logic [32:0] k);
    int n = 0;
    qe.push_back(x);
    qm.push_back(k);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= wn;
    pa <= a;
    pw <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (prdy !== 1'b1 && n < 3000);
    if (prdy !== 1'b1) begin
      n_fail++;
      $display("mismatch at %0t: bus access never answered", $time);
    end
    rd = prd;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : acc
  task automatic poll(input int b);
    rd = 32'h0;
    for (int k = 0; k < 400 && rd[b] !== 1'b1; k++) acc(1'b0, OFS_STATUS, 32'h0, 33'h0, 33'h0);
    if (rd[b] !== 1'b1) begin
      n_fail++;
      $display("mismatch at %0t: status bit %0d never set", $time, b);
    end
  endtask : poll
  always @(posedge clk) begin
    if (rst_n && prdy === 1'b1) begin
      e = qe.pop_front();
      m = qm.pop_front();
      chk({perr, prd}, e, m);
    end
    if (rst_n && ev === 1'b1) begin
      chk({17'h0, ed}, {17'h0, qp.pop_front()}, 33'hffff);
      chk({17'h0, dout}, {17'h0, ed}, {17'h0, {16{om}}});
      chk({31'h0, doe, rv}, {31'h0, !om, !om}, 33'h3);
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    acc(1'b0, OFS_CFG_ONE, 32'h0, 33'h0, 33'h1ffffffff);
    acc(1'b0, OFS_STATUS, 32'h0, 33'h2, 33'h13);
    chk({25'h0, coe}, 33'hff, 33'hff);
    acc(1'b0, 8'h1c, 32'h0, 33'h100000000, 33'h100000000);
    om = 1'b1;
    for (int i = 0; i < 10; i++) begin
      w = 16'($random(seed));
      wd.push_back(w);
      qp.push_back(w);
    end
    acc(1'b1, OFS_CFG_TWO, 32'h1, 33'h0, 33'h0);
    acc(1'b1, OFS_CFG_TWO, 32'hff1, 33'h0, 33'h0);
    chk({25'h0, coe}, 33'h0, 33'hff);
    acc(1'b1, OFS_COUNT, 32'ha, 33'h0, 33'h0);
    acc(1'b1, OFS_CFG_ONE, 32'h8032, 33'h0, 33'h0);
    for (int i = 0; i < 10; i++) begin
      if (i == 8) poll(ST_EMPTY);
      acc(1'b1, OFS_DATA, {16'h0, wd[i]}, 33'h0, 33'h0);
    end
    acc(1'b1, OFS_DATA, 32'hbeef, 33'h0, 33'h0);
    acc(1'b0, OFS_STATUS, 32'h0, 33'h8, 33'h8);
    poll(ST_EOT);
    om = 1'b0;
    arm = 1'b1;
    for (int i = 0; i < 12; i++) qp.push_back(16'h3c00 + 16'(i));
    acc(1'b1, OFS_CFG_TWO, 32'hff3, 33'h0, 33'h0);
    acc(1'b1, OFS_COUNT, 32'hc, 33'h0, 33'h0);
    acc(1'b1, OFS_CFG_ONE, 32'h82f1, 33'h0, 33'h0);
    for (int i = 0; i < 10; i++) acc(1'b0, OFS_DATA, 32'h0, {17'h0, 8'(i), 8'h3c}, 33'hffff);
    poll(ST_EOT);
    acc(1'b1, OFS_CFG_TWO, 32'h2ff3, 33'h0, 33'h0);
    acc(1'b0, OFS_STATUS, 32'h0, 33'h2, 33'h3);
    chk(33'(qp.size()), 33'h0, 33'h1ff);
    summarize();
  end
  initial begin
    #3000000;
    n_fail++;
    summarize();
  end
  task automatic summarize();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize
endmodule : tb
bind ppfs_top ppfs_props ppfs_props_inst (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PREADY(PREADY), .PADDR(PADDR), .PWDATA(PWDATA), .DATA_OUT(DATA_OUT),
  .DATA_OE_N(DATA_OE_N), .CTRL_OUT(CTRL_OUT), .ECC_DATA(ECC_DATA), .ECC_VALID(ECC_VALID));
